/* File: rtl/spk_prot_regs.svh */
// Register offsets, fields, reset values and timing counts for speaker protection
`ifndef SPK_PROT_REGS_SVH
`define SPK_PROT_REGS_SVH
`define TIMER_SEL_ADDR 16'h026D
`define TIMER_SEL_RESET 4'h0
`define TIMER_SEL_MSB 3
`define TIMER_SEL_LSB 0
`define TIMER_SEL_OFF 4'h0
`define TIMER_SEL_MAX 4'h4
`define OFF_RAMP_CYCLES 8
`define GPIO_SRC_THERMAL 2'h0
`define GPIO_SRC_SPK_SHORT 2'h1
`define GPIO_SRC_SPK_OFF 2'h2
`endif

/* File: rtl/spk_prot_pkg.sv */
// Types for the speaker protection block
package spk_prot_pkg;
  typedef enum logic [4:0] {
    SPK_IDLE = 5'h01,
    SPK_CHECK = 5'h02,
    SPK_RUN = 5'h04,
    SPK_RAMP = 5'h08,
    SPK_HOLD = 5'h10
  } spk_state_t;
  typedef logic [1:0] gpio_src_t;
endpackage

/* File: rtl/speaker_protection_shutdown.sv */
// Thermal, short-circuit and timer driven shutdown of the speaker drivers
`timescale 1ns/1ps
`include "spk_prot_regs.svh"

// Behaviour
// - Warning and critical temperature thresholds each raise their own event.
// - Crossing the critical threshold turns the speaker drivers off with no host action.
// - When any protective speaker shutdown has finished, a shutdown-done event is raised.
// - A speaker enable request checks for a short first and fails, driver off, if one is seen.
// - A speaker short raises an event and turns the speaker drivers off.
// - Speaker short status is cleared whenever the speaker enable request is low.
// - Headphone and earpiece short monitoring runs all the time their driver is on.
// - A headphone or earpiece short current-limits that driver and keeps it running.
// - Headphone and earpiece shorts each raise their own event.
// - A 4-bit field picks the shutdown timer: 0 off, 1 to 4 timers, others reserved.
// - The selected timer reaching its final count turns the speaker drivers off.
// - A timer shutdown raises the shutdown-done event once it has finished.
// - Thermal, speaker short and speaker shutdown flags can be routed to a GPIO.
module speaker_protection_shutdown #(
  parameter int OFF_RAMP = `OFF_RAMP_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata_q,
  input wire logic temp_warn_raw,
  input wire logic temp_crit_raw,
  input wire logic spk_short_raw,
  input wire logic hp_short_raw,
  input wire logic ep_short_raw,
  input wire logic spk_en_req,
  input wire logic hp_en,
  input wire logic ep_en,
  input wire logic [3:0] timer_final,
  input wire spk_prot_pkg::gpio_src_t gpio_src,
  output logic spk_drv_en_q,
  output logic hp_ilimit_q,
  output logic ep_ilimit_q,
  output logic spk_short_sts_q,
  output logic spk_off_sts_q,
  output logic temp_warning_event,
  output logic temp_critical_event,
  output logic speaker_off_done_event,
  output logic spk_short_event,
  output logic hp_short_event,
  output logic ep_short_event,
  output logic gpio_flag_q
);
  import spk_prot_pkg::*;

  function automatic logic timer_hit(input logic [3:0] sel, input logic [3:0] fin);
    logic hit;
    hit = 1'b0;
    if (sel != `TIMER_SEL_OFF && sel <= `TIMER_SEL_MAX) begin
      hit = fin[sel[1:0] - 2'h1];
    end
    return hit;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for analog detector levels
  logic [4:0] raw_m_q;
  logic [4:0] raw_s_q;
  logic [1:0] temp_p_q;
  logic warn_s, crit_s, spks_s, hps_s, eps_s;
  assign {warn_s, crit_s, spks_s, hps_s, eps_s} = raw_s_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      raw_m_q <= 5'h00;
      raw_s_q <= 5'h00;
      temp_p_q <= 2'h0;
    end else begin
      raw_m_q <= {temp_warn_raw, temp_crit_raw, spk_short_raw, hp_short_raw, ep_short_raw};
      raw_s_q <= raw_m_q;
      temp_p_q <= {warn_s, crit_s};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer select register
  logic [3:0] timer_sel_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_sel_q <= `TIMER_SEL_RESET;
    end else if (reg_wr && reg_addr == `TIMER_SEL_ADDR) begin
      timer_sel_q <= reg_wdata[`TIMER_SEL_MSB:`TIMER_SEL_LSB];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= 16'h0000;
    end else if (reg_addr == `TIMER_SEL_ADDR) begin
      reg_rdata_q <= {12'h000, timer_sel_q};
    end else begin
      reg_rdata_q <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Speaker driver sequencer
  spk_state_t state_q;
  logic [7:0] ramp_q;
  logic trip;
  logic timer_trip;
  assign timer_trip = timer_hit(timer_sel_q, timer_final);
  assign trip = crit_s | spks_s | timer_trip;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SPK_IDLE;
      ramp_q <= 8'h00;
    end else begin
      case (state_q)
        SPK_IDLE: begin
          if (spk_en_req) begin
            state_q <= SPK_CHECK;
          end
        end
        SPK_CHECK: begin
          if (!spk_en_req) begin
            state_q <= SPK_IDLE;
          end else if (spks_s) begin
            state_q <= SPK_HOLD;
          end else if (trip) begin
            state_q <= SPK_RAMP;
            ramp_q <= 8'(OFF_RAMP - 1);
          end else begin
            state_q <= SPK_RUN;
          end
        end
        SPK_RUN: begin
          if (trip) begin
            state_q <= SPK_RAMP;
            ramp_q <= 8'(OFF_RAMP - 1);
          end else if (!spk_en_req) begin
            state_q <= SPK_IDLE;
          end
        end
        SPK_RAMP: begin
          if (ramp_q == 8'h00) begin
            state_q <= SPK_HOLD;
          end else begin
            ramp_q <= ramp_q - 8'h01;
          end
        end
        SPK_HOLD: begin
          if (!spk_en_req) begin
            state_q <= SPK_IDLE;
          end
        end
        default: state_q <= SPK_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      spk_drv_en_q <= 1'b0;
      speaker_off_done_event <= 1'b0;
      spk_off_sts_q <= 1'b0;
    end else begin
      spk_drv_en_q <= (state_q == SPK_CHECK && spk_en_req && !trip)
                      || (state_q == SPK_RUN && spk_en_req && !trip);
      speaker_off_done_event <= (state_q == SPK_RAMP && ramp_q == 8'h00);
      if (state_q == SPK_RAMP && ramp_q == 8'h00) begin
        spk_off_sts_q <= 1'b1;
      end else if (!spk_en_req) begin
        spk_off_sts_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Short status, current limit and events
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      spk_short_sts_q <= 1'b0;
      spk_short_event <= 1'b0;
    end else begin
      if (!spk_en_req) begin
        spk_short_sts_q <= 1'b0;
      end else if (spks_s && (state_q == SPK_CHECK || state_q == SPK_RUN)) begin
        spk_short_sts_q <= 1'b1;
      end
      spk_short_event <= spk_en_req && spks_s && !spk_short_sts_q
                         && (state_q == SPK_CHECK || state_q == SPK_RUN);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hp_ilimit_q <= 1'b0;
      ep_ilimit_q <= 1'b0;
      hp_short_event <= 1'b0;
      ep_short_event <= 1'b0;
    end else begin
      hp_ilimit_q <= hp_en & hps_s;
      ep_ilimit_q <= ep_en & eps_s;
      hp_short_event <= hp_en & hps_s & ~hp_ilimit_q;
      ep_short_event <= ep_en & eps_s & ~ep_ilimit_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_warning_event <= 1'b0;
      temp_critical_event <= 1'b0;
      gpio_flag_q <= 1'b0;
    end else begin
      temp_warning_event <= warn_s & ~temp_p_q[1];
      temp_critical_event <= crit_s & ~temp_p_q[0];
      case (gpio_src)
        `GPIO_SRC_THERMAL: gpio_flag_q <= crit_s;
        `GPIO_SRC_SPK_SHORT: gpio_flag_q <= spk_short_sts_q;
        `GPIO_SRC_SPK_OFF: gpio_flag_q <= spk_off_sts_q;
        default: gpio_flag_q <= 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_CRIT_KILLS: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == SPK_RUN && crit_s) |=> !spk_drv_en_q)
    else $error("critical temperature left speaker on");

  AST_DONE_AFTER_RAMP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == SPK_RUN && trip) |=> ##[1:300] speaker_off_done_event)
    else $error("shutdown done event missing");

  AST_SHORT_BLOCKS_EN: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == SPK_CHECK && spks_s) |=> !spk_drv_en_q ##1 !spk_drv_en_q)
    else $error("enable succeeded into a short");

  AST_SHORT_EVENT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == SPK_RUN && spk_en_req && spks_s && !spk_short_sts_q) |=> spk_short_event)
    else $error("speaker short event missing");

  AST_STS_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !spk_en_req |=> !spk_short_sts_q)
    else $error("short status kept while disabled");

  AST_HP_LIMIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (hp_en && hps_s) |=> hp_ilimit_q)
    else $error("headphone current limit missing");

  AST_EP_EVENT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(ep_en && eps_s) && !$past(eps_s) |=> ep_short_event)
    else $error("earpiece short event missing");

  AST_TIMER_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (timer_sel_q == 4'h0 || timer_sel_q > 4'h4) |-> !timer_trip)
    else $error("disabled timer selection tripped");

  AST_HOLD_UNTIL_LOW: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == SPK_HOLD) |=> !spk_drv_en_q ##1 !spk_drv_en_q)
    else $error("driver restarted without enable cycle");

  AST_WARN_EVENT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(warn_s) |=> temp_warning_event ##1 !temp_warning_event)
    else $error("warning event not a single pulse");

  AST_CRIT_EVENT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(crit_s) |=> temp_critical_event)
    else $error("critical temperature event missing");

  AST_CHECK_TRIP_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == SPK_CHECK && trip) |=> !spk_drv_en_q)
    else $error("enable succeeded into a trip condition");

  AST_OFF_STS_SET: assert property (@(posedge ref_clk) disable iff (!rst_n)
    speaker_off_done_event |-> spk_off_sts_q)
    else $error("shutdown status missing with done event");

  AST_DONE_PULSE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    speaker_off_done_event |=> !speaker_off_done_event)
    else $error("shutdown done event longer than one cycle");

  AST_SHORT_KILLS: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == SPK_RUN && spks_s) |=> !spk_drv_en_q)
    else $error("speaker short left speaker on");

  AST_STS_SET: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == SPK_RUN && spk_en_req && spks_s) |=> spk_short_sts_q)
    else $error("speaker short status not set");

  AST_HP_ONLY_ON: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !hp_en |=> (!hp_ilimit_q && !hp_short_event))
    else $error("headphone monitoring active while driver off");

  AST_EP_ONLY_ON: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !ep_en |=> (!ep_ilimit_q && !ep_short_event))
    else $error("earpiece monitoring active while driver off");

  AST_EP_LIMIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ep_en && eps_s) |=> ep_ilimit_q)
    else $error("earpiece current limit missing");

  AST_HP_EVENT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(hp_en && hps_s) |=> hp_short_event)
    else $error("headphone short event missing");

  AST_TIMER_KILLS: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == SPK_RUN && timer_trip) |=> !spk_drv_en_q)
    else $error("timer expiry left speaker on");

  AST_TIMER_DONE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == SPK_RUN && timer_trip) |=> ##[1:300] speaker_off_done_event)
    else $error("timer shutdown done event missing");

  AST_GPIO_THERMAL: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (gpio_src == `GPIO_SRC_THERMAL) |=> (gpio_flag_q == $past(crit_s)))
    else $error("thermal flag not on gpio");

  AST_GPIO_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (gpio_src == `GPIO_SRC_SPK_OFF) |=> (gpio_flag_q == $past(spk_off_sts_q)))
    else $error("shutdown flag not on gpio");

  AST_HOLD_STAYS: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == SPK_HOLD && spk_en_req) |=> (state_q == SPK_HOLD))
    else $error("hold left while enable still high");
endmodule

/* File: bench/spk_load_model.sv */
// Output load model driving the short-circuit detector levels
`timescale 1ns/1ps
module spk_load_model (
  input wire logic [2:0] fault,
  output logic spk_short_raw,
  output logic hp_short_raw,
  output logic ep_short_raw
);
  // A shorted load is seen by its detector even while its driver is off
  assign spk_short_raw = fault[0];
  assign hp_short_raw = fault[1];
  assign ep_short_raw = fault[2];
endmodule

/* File: bench/test_speaker_protection_shutdown.sv */
// Self-checking bench for the speaker protection shutdown block
`timescale 1ns/1ps
`include "spk_prot_regs.svh"
module test_speaker_protection_shutdown;
  import spk_prot_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic reg_wr = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic temp_warn_raw = 1'b0, temp_crit_raw = 1'b0, spk_en_req = 1'b0;
  logic hp_en = 1'b0, ep_en = 1'b0;
  logic [2:0] fault = 3'h0;
  logic [3:0] timer_final = 4'h0;
  gpio_src_t gpio_src = 2'h0;
  logic [15:0] reg_rdata_q;
  logic spk_short_raw, hp_short_raw, ep_short_raw, spk_drv_en_q, hp_ilimit_q, ep_ilimit_q;
  logic spk_short_sts_q, spk_off_sts_q, gpio_flag_q, temp_warning_event, temp_critical_event;
  logic speaker_off_done_event, spk_short_event, hp_short_event, ep_short_event;
  int miscompares = 0;
  int checks = 0;
  wire [5:0] ev = {temp_warning_event, temp_critical_event, speaker_off_done_event,
    spk_short_event, hp_short_event, ep_short_event};
  always #2.5 ref_clk = ~ref_clk;
  speaker_protection_shutdown #(.OFF_RAMP(2)) speaker_protection_shutdown_inst (.ref_clk,
    .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata_q, .temp_warn_raw, .temp_crit_raw,
    .spk_short_raw, .hp_short_raw, .ep_short_raw, .spk_en_req, .hp_en, .ep_en, .timer_final,
    .gpio_src, .spk_drv_en_q, .hp_ilimit_q, .ep_ilimit_q, .spk_short_sts_q, .spk_off_sts_q,
    .temp_warning_event, .temp_critical_event, .speaker_off_done_event, .spk_short_event,
    .hp_short_event, .ep_short_event, .gpio_flag_q);
  spk_load_model spk_load_model_inst (.fault, .spk_short_raw, .hp_short_raw, .ep_short_raw);
  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic reg_write(input logic [15:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
  endtask
  task automatic reg_read(input logic [15:0] a, input logic [15:0] exp);
    reg_addr = a;
    tick(1);
    check(reg_rdata_q, exp);
  endtask
  // Bounded wait for one event pulse
  task automatic wait_ev(input int i);
    int n;
    n = 0;
    while (ev[i] !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    check(16'(ev[i]), 16'h0001);
  endtask
  // Host restart: enable low, then high again
  task automatic restart();
    spk_en_req = 1'b0;
    tick(2);
    spk_en_req = 1'b1;
    tick(3);
  endtask
  task automatic finish_test();
    if (miscompares == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    miscompares++;
    finish_test();
  end
  initial begin
    tick(6);
    rst_n = 1'b1;
    tick(1);
    reg_read(`TIMER_SEL_ADDR, 16'h0000);
    reg_write(`TIMER_SEL_ADDR, 16'hFFF3);
    reg_read(`TIMER_SEL_ADDR, 16'h0003);
    reg_read(16'h026C, 16'h0000);
    reg_write(`TIMER_SEL_ADDR, 16'h0000);
    spk_en_req = 1'b1;
    tick(3);
    check(spk_drv_en_q, 1'b1);
    temp_warn_raw = 1'b1;
    wait_ev(5);
    check(spk_drv_en_q, 1'b1);
    temp_crit_raw = 1'b1;
    wait_ev(4);
    check(spk_drv_en_q, 1'b0);
    wait_ev(3);
    check(spk_off_sts_q, 1'b1);
    gpio_src = `GPIO_SRC_THERMAL;
    tick(2);
    check(gpio_flag_q, 1'b1);
    gpio_src = `GPIO_SRC_SPK_OFF;
    tick(2);
    check(gpio_flag_q, 1'b1);
    restart();
    check(spk_drv_en_q, 1'b0);
    wait_ev(3);
    temp_crit_raw = 1'b0;
    temp_warn_raw = 1'b0;
    tick(5);
    check(spk_drv_en_q, 1'b0);
    restart();
    check(spk_drv_en_q, 1'b1);
    check(spk_off_sts_q, 1'b0);
    fault = 3'h1;
    wait_ev(2);
    check(spk_drv_en_q, 1'b0);
    wait_ev(3);
    gpio_src = `GPIO_SRC_SPK_SHORT;
    tick(2);
    check(gpio_flag_q, 1'b1);
    gpio_src = 2'h3;
    tick(2);
    check(gpio_flag_q, 1'b0);
    spk_en_req = 1'b0;
    tick(2);
    check(spk_short_sts_q, 1'b0);
    spk_en_req = 1'b1;
    tick(5);
    check(spk_drv_en_q, 1'b0);
    fault = 3'h0;
    restart();
    check(spk_drv_en_q, 1'b1);
    for (int k = 1; k <= 4; k++) begin
      reg_write(`TIMER_SEL_ADDR, 16'(k));
      timer_final = 4'hF ^ (4'h1 << (k - 1));
      tick(4);
      check(spk_drv_en_q, 1'b1);
      timer_final = 4'h1 << (k - 1);
      wait_ev(3);
      check(spk_drv_en_q, 1'b0);
      timer_final = 4'h0;
      restart();
    end
    reg_write(`TIMER_SEL_ADDR, 16'h0005);
    timer_final = 4'hF;
    tick(6);
    check(spk_drv_en_q, 1'b1);
    reg_write(`TIMER_SEL_ADDR, 16'h0000);
    tick(6);
    check(spk_drv_en_q, 1'b1);
    fault = 3'h6;
    tick(4);
    check(hp_ilimit_q, 1'b0);
    check(ep_ilimit_q, 1'b0);
    check(16'(ev), 16'h0000);
    hp_en = 1'b1;
    wait_ev(1);
    check(hp_ilimit_q, 1'b1);
    check(ep_ilimit_q, 1'b0);
    ep_en = 1'b1;
    wait_ev(0);
    check(ep_ilimit_q, 1'b1);
    hp_en = 1'b0;
    tick(2);
    check(hp_ilimit_q, 1'b0);
    check(ep_ilimit_q, 1'b1);
    finish_test();
  end
endmodule
